// file: hw/pcs_pkg.sv
package pcs_pkg;

   // configuration header byte offsets
   localparam logic [7:0] OFS_MANUFACTURER_CODE = 8'h00;
   localparam logic [7:0] OFS_PART_CODE = 8'h02;
   localparam logic [7:0] OFS_COMMAND_CONTROL = 8'h04;
   localparam logic [7:0] OFS_STATUS_FLAGS = 8'h06;
   localparam logic [7:0] OFS_CLASS_AND_REVISION = 8'h08;
   localparam logic [7:0] OFS_MEMORY_WINDOW_BASE = 8'h10;
   localparam logic [7:0] OFS_ROM_WINDOW_BASE = 8'h30;
   localparam logic [7:0] OFS_IRQ_ROUTING = 8'h3c;
   localparam logic [7:0] OFS_IRQ_PIN_SELECT = 8'h3d;

   // dword indexes seen on ad[7:2]
   localparam logic [5:0] IDX_IDENT = OFS_MANUFACTURER_CODE[7:2];
   localparam logic [5:0] IDX_CMD_STAT = OFS_COMMAND_CONTROL[7:2];
   localparam logic [5:0] IDX_CLASS = OFS_CLASS_AND_REVISION[7:2];
   localparam logic [5:0] IDX_MEM_BASE = OFS_MEMORY_WINDOW_BASE[7:2];
   localparam logic [5:0] IDX_ROM_BASE = OFS_ROM_WINDOW_BASE[7:2];
   localparam logic [5:0] IDX_IRQ = OFS_IRQ_ROUTING[7:2];

   // command_control field positions
   localparam int CMD_IO_EN_BIT = 0;
   localparam int CMD_MEM_EN_BIT = 1;
   localparam int CMD_SNOOP_BIT = 5;

   // status_flags: medium device-select timing code in bits 10..9
   localparam int STAT_DEVSEL_LSB = 9;
   localparam logic [1:0] STAT_DEVSEL_MEDIUM = 2'h1;

   // class code: vga-compatible display controller
   localparam logic [23:0] CLASS_VGA_DISPLAY = 24'h030000;

   // memory_window_base layout
   localparam int MEM_BASE_LSB = 23;
   localparam int MEM_BASE_W = 9;
   localparam logic MEM_SPACE_IND = 1'h0;
   localparam logic [1:0] MEM_TYPE_32BIT = 2'h0;
   localparam logic MEM_NOT_PREFETCH = 1'h0;

   // rom_window_base layout
   localparam int ROM_EN_BIT = 0;
   localparam int ROM_BASE_LSB = 16;
   localparam int ROM_BASE_W = 16;

   // irq_pin_select code for the first interrupt pin
   localparam logic [7:0] IRQ_PIN_INTA = 8'h01;

   // writable bit masks per dword
   localparam logic [31:0] WMASK_CMD_STAT = 32'h0000_0023;
   localparam logic [31:0] WMASK_MEM_BASE = 32'hff80_0000;
   localparam logic [31:0] WMASK_ROM_BASE = 32'hffff_0001;
   localparam logic [31:0] WMASK_IRQ = 32'h0000_00ff;

   // bus commands on cbe_n during the address phase
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

   typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_DATA, ST_TURN} pcs_fsm_t;

   // software-visible configuration, all writable fields reset to zero
   typedef struct packed {
      logic io_en;
      logic mem_en;
      logic snoop_en;
      logic [MEM_BASE_W-1:0] mem_base;
      logic rom_en;
      logic [ROM_BASE_W-1:0] rom_base;
      logic [7:0] irq_line;
   } pcs_cfg_t;

   typedef struct packed {
      logic io_claim;
      logic mem_claim;
      logic rom_claim;
   } pcs_claim_t;

endpackage

// file: hw/pcs_byte_merge.sv
`timescale 1ns/1ps
module pcs_byte_merge
   import pcs_pkg::*;
(
   input wire logic [31:0] old_word,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] be_n,
   input wire logic [31:0] wr_mask,
   output logic [31:0] new_word
);

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         // a bit changes only if its lane is enabled and the bit is writable
         assign new_word[g*8 +: 8] = be_n[g] ? old_word[g*8 +: 8] :
            ((wr_data[g*8 +: 8] & wr_mask[g*8 +: 8]) |
             (old_word[g*8 +: 8] & ~wr_mask[g*8 +: 8]));
      end
   endgenerate

endmodule

// file: hw/pcs_window_dec.sv
`timescale 1ns/1ps
module pcs_window_dec
   import pcs_pkg::*;
(
   input wire logic addr_phase,
   input wire logic [3:0] cbe_n,
   input wire logic [31:0] ad_in,
   input wire pcs_cfg_t cfg,
   output pcs_claim_t claim
);

   logic io_cmd;
   logic mem_cmd;

   always_comb
   begin
      io_cmd = (cbe_n == CMD_IO_RD) || (cbe_n == CMD_IO_WR);
      mem_cmd = (cbe_n == CMD_MEM_RD) || (cbe_n == CMD_MEM_WR) ||
         (cbe_n == CMD_MEM_RD_MULT) || (cbe_n == CMD_MEM_RD_LINE) ||
         (cbe_n == CMD_MEM_WR_INV);
      // port decode itself lives elsewhere; this only gates it
      claim.io_claim = addr_phase && io_cmd && cfg.io_en;
      claim.mem_claim = addr_phase && mem_cmd && cfg.mem_en &&
         (ad_in[MEM_BASE_LSB +: MEM_BASE_W] == cfg.mem_base);
      // rom needs its own enable and the memory space enable
      claim.rom_claim = addr_phase && mem_cmd && cfg.mem_en && cfg.rom_en &&
         (ad_in[ROM_BASE_LSB +: ROM_BASE_W] == cfg.rom_base);
   end

endmodule

// file: hw/pcs_cfg_header.sv
`timescale 1ns/1ps
// Summary of operation
// - the target dword is selected by the register byte address on ad[7:0] of a config cycle.
// - command bit 0 is writable and enables answering i/o space accesses.
// - command bit 1 is writable and enables answering memory space accesses.
// - status bits 10..9 always read the medium device-select code and ignore writes.
// - the 32-bit class and revision word is read-only and names a vga display controller.
// - memory window base bit 0 always reads as memory space.
// - memory window base bits 2..1 always read as anywhere in 32-bit space.
// - memory window base bit 3 always reads as not prefetchable.
// - rom window base bit 0 is writable and enables decode of the rom window.
// - rom window base bits 31..16 are writable and give the rom window address.
// - the interrupt line byte is plain read/write storage with no effect on the device.
// - the interrupt pin byte is read-only and names the first interrupt pin.
module pcs_cfg_header
   import pcs_pkg::*;
#(
   // arbitrary identity values
   parameter logic [15:0] MANUFACTURER_CODE = 16'h1a2b,
   parameter logic [15:0] PART_CODE = 16'h0c0d,
   parameter logic [7:0] REVISION = 8'h01
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic idsel,
   input wire logic [3:0] cbe_n,
   input wire logic [31:0] ad_in,
   output logic [31:0] ad_out,
   output logic ad_oe_n,
   output logic par_out,
   output logic par_oe_n,
   output logic trdy_n,
   output logic stop_n,
   output logic devsel_n,
   output logic ctl_oe_n,
   output pcs_cfg_t cfg,
   output pcs_claim_t claim
);

   typedef struct packed {
      pcs_fsm_t fsm;
      logic frame_q;
      logic [5:0] idx;
      logic is_write;
      logic [31:0] ad_out;
      logic par;
      logic par_drv;
      pcs_cfg_t cfg;
   } pcs_state_t;

   pcs_state_t s_r;
   pcs_state_t s_nxt;

   logic addr_phase;
   logic cfg_cmd;
   logic [31:0] rd_word;
   logic [31:0] wr_mask;
   logic [31:0] merged;

   // a new address phase starts when frame falls from an idle bus
   assign addr_phase = !frame_n && s_r.frame_q;
   // type 0 configuration commands addressed to this slot
   assign cfg_cmd = idsel && (ad_in[1:0] == 2'h0) &&
      ((cbe_n == CMD_CFG_RD) || (cbe_n == CMD_CFG_WR));

   // read view of the selected dword
   always_comb
   begin
      rd_word = 32'h0;
      unique case (s_r.idx)
         IDX_IDENT:
            rd_word = {PART_CODE, MANUFACTURER_CODE};
         IDX_CMD_STAT:
         begin
            rd_word[CMD_IO_EN_BIT] = s_r.cfg.io_en;
            rd_word[CMD_MEM_EN_BIT] = s_r.cfg.mem_en;
            rd_word[CMD_SNOOP_BIT] = s_r.cfg.snoop_en;
            rd_word[16 + STAT_DEVSEL_LSB +: 2] = STAT_DEVSEL_MEDIUM;
         end
         IDX_CLASS:
            rd_word = {CLASS_VGA_DISPLAY, REVISION};
         IDX_MEM_BASE:
         begin
            rd_word[0] = MEM_SPACE_IND;
            rd_word[2:1] = MEM_TYPE_32BIT;
            rd_word[3] = MEM_NOT_PREFETCH;
            rd_word[MEM_BASE_LSB +: MEM_BASE_W] = s_r.cfg.mem_base;
         end
         IDX_ROM_BASE:
         begin
            rd_word[ROM_EN_BIT] = s_r.cfg.rom_en;
            rd_word[ROM_BASE_LSB +: ROM_BASE_W] = s_r.cfg.rom_base;
         end
         IDX_IRQ:
            rd_word = {16'h0, IRQ_PIN_INTA, s_r.cfg.irq_line};
         default:
            rd_word = 32'h0;
      endcase
   end

   // only writable bits pass; hardwired and reserved bits keep their value
   always_comb
   begin
      unique case (s_r.idx)
         IDX_CMD_STAT:
            wr_mask = WMASK_CMD_STAT;
         IDX_MEM_BASE:
            wr_mask = WMASK_MEM_BASE;
         IDX_ROM_BASE:
            wr_mask = WMASK_ROM_BASE;
         IDX_IRQ:
            wr_mask = WMASK_IRQ;
         default:
            wr_mask = 32'h0;
      endcase
   end

   pcs_byte_merge u_merge (
      .old_word(rd_word),
      .wr_data(ad_in),
      .be_n(cbe_n),
      .wr_mask(wr_mask),
      .new_word(merged)
   );

   pcs_window_dec u_win (
      .addr_phase(addr_phase),
      .cbe_n(cbe_n),
      .ad_in(ad_in),
      .cfg(s_r.cfg),
      .claim(claim)
   );

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.frame_q = frame_n;
      // parity trails the read data by one clock
      s_nxt.par = ^{s_r.ad_out, cbe_n};
      s_nxt.par_drv = (s_r.fsm == ST_DATA) && !s_r.is_write;
      unique case (s_r.fsm)
         ST_IDLE:
         begin
            if (addr_phase && cfg_cmd)
            begin
               s_nxt.fsm = ST_DECODE;
               s_nxt.idx = ad_in[7:2];
               s_nxt.is_write = (cbe_n == CMD_CFG_WR);
            end
         end
         ST_DECODE:
         begin
            // second clock after the address phase: medium devsel
            s_nxt.fsm = ST_DATA;
            s_nxt.ad_out = rd_word;
         end
         ST_DATA:
         begin
            if (!irdy_n)
            begin
               s_nxt.fsm = ST_TURN;
               if (s_r.is_write)
               begin
                  unique case (s_r.idx)
                     IDX_CMD_STAT:
                     begin
                        s_nxt.cfg.io_en = merged[CMD_IO_EN_BIT];
                        s_nxt.cfg.mem_en = merged[CMD_MEM_EN_BIT];
                        s_nxt.cfg.snoop_en = merged[CMD_SNOOP_BIT];
                     end
                     IDX_MEM_BASE:
                        s_nxt.cfg.mem_base = merged[MEM_BASE_LSB +: MEM_BASE_W];
                     IDX_ROM_BASE:
                     begin
                        s_nxt.cfg.rom_en = merged[ROM_EN_BIT];
                        s_nxt.cfg.rom_base = merged[ROM_BASE_LSB +: ROM_BASE_W];
                     end
                     IDX_IRQ:
                        s_nxt.cfg.irq_line = merged[7:0];
                     default:
                        s_nxt.cfg = s_r.cfg;
                  endcase
               end
            end
         end
         ST_TURN:
            s_nxt.fsm = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // control lines are driven high for one turn-around clock before release
   assign ctl_oe_n = !((s_r.fsm == ST_DATA) || (s_r.fsm == ST_TURN));
   assign devsel_n = (s_r.fsm != ST_DATA);
   assign trdy_n = (s_r.fsm != ST_DATA);
   // single data phase only: a burst gets a disconnect with the first data
   assign stop_n = !((s_r.fsm == ST_DATA) && !frame_n);
   assign ad_out = s_r.ad_out;
   assign ad_oe_n = !((s_r.fsm == ST_DATA) && !s_r.is_write);
   assign par_out = s_r.par;
   assign par_oe_n = !s_r.par_drv;
   assign cfg = s_r.cfg;

endmodule

// file: testbench/pcs_cfg_header_sva.sv
`timescale 1ns/1ps
module pcs_cfg_header_chk
   import pcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic idsel,
   input wire logic [3:0] cbe_n,
   input wire logic [31:0] ad_in,
   input wire logic [31:0] ad_out,
   input wire logic ad_oe_n,
   input wire logic par_out,
   input wire logic par_oe_n,
   input wire logic trdy_n,
   input wire logic stop_n,
   input wire logic devsel_n,
   input wire logic ctl_oe_n,
   input wire pcs_cfg_t cfg,
   input wire pcs_claim_t claim
);
   logic frame_q;
   logic addr_ph;
   logic mem_cmd;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // same start-up view as the design: no address phase on the first edge
   always_ff @(posedge clk or posedge rst)
      if (rst)
         frame_q <= 1'b0;
      else
         frame_q <= frame_n;
   assign addr_ph = !frame_n && frame_q;
   assign mem_cmd = cbe_n inside {CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE,
      CMD_MEM_WR_INV};
   property p_cfg_ans;
      addr_ph && idsel && cbe_n[3:1] == 3'h5 && ad_in[1:0] == 2'h0 |-> ##2 !devsel_n && !trdy_n;
   endproperty
   a_cfg_ans: assert property (p_cfg_ans) else $error("config cycle not answered");
   property p_no_sel;
      addr_ph && !idsel |-> ##1 devsel_n [*3];
   endproperty
   a_no_sel: assert property (p_no_sel) else $error("answered without idsel");
   property p_io;
      addr_ph && cbe_n[3:1] == 3'h1 |-> claim.io_claim == cfg.io_en;
   endproperty
   a_io: assert property (p_io) else $error("io claim wrong");
   property p_mem;
      addr_ph && mem_cmd |-> claim.mem_claim == (cfg.mem_en && ad_in[31:23] == cfg.mem_base);
   endproperty
   a_mem: assert property (p_mem) else $error("memory claim wrong");
   property p_rom;
      addr_ph && mem_cmd |->
         claim.rom_claim == (cfg.mem_en && cfg.rom_en && ad_in[31:16] == cfg.rom_base);
   endproperty
   a_rom: assert property (p_rom) else $error("rom claim wrong");
   property p_claim_ph;
      claim != 3'h0 |-> addr_ph;
   endproperty
   a_claim_ph: assert property (p_claim_ph) else $error("claim outside address phase");
   property p_cfg_hold;
      !$stable(cfg) |-> $past(!trdy_n && !irdy_n);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");
   property p_one_phase;
      !trdy_n && !irdy_n |=> trdy_n && devsel_n;
   endproperty
   a_one_phase: assert property (p_one_phase) else $error("data phase not ended");
   property p_rst_clr;
      $fell(rst) |-> cfg == '0;
   endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("config not cleared by reset");
   // even parity over the read data phase, driven in the clock after it
   property p_par;
      !trdy_n && !irdy_n && !ad_oe_n |=>
         !par_oe_n && par_out == ^{$past(ad_out), $past(cbe_n)};
   endproperty
   a_par: assert property (p_par) else $error("read parity wrong");
   property p_turn;
      !trdy_n && !irdy_n |=> !ctl_oe_n && ad_oe_n ##1 ctl_oe_n && par_oe_n;
   endproperty
   a_turn: assert property (p_turn) else $error("turn-around not kept");
   property p_stop;
      !devsel_n && frame_n |-> stop_n;
   endproperty
   a_stop: assert property (p_stop) else $error("disconnect on last data phase");
endmodule

bind pcs_cfg_header pcs_cfg_header_chk u_chk (.clk, .rst, .frame_n, .irdy_n, .idsel, .cbe_n,
   .ad_in, .ad_out, .ad_oe_n, .par_out, .par_oe_n, .trdy_n, .stop_n, .devsel_n, .ctl_oe_n,
   .cfg, .claim);

// file: testbench/pcs_host_model.sv
`timescale 1ns/1ps
module pcs_host_model
   import pcs_pkg::*;
(
   input wire logic clk,
   input wire logic [31:0] ad_out,
   input wire logic ad_oe_n,
   input wire logic trdy_n,
   input wire pcs_claim_t claim,
   output logic frame_n,
   output logic irdy_n,
   output logic idsel,
   output logic [3:0] cbe_n,
   output logic [31:0] ad_in
);
   logic [31:0] ad_h;
   logic ad_h_oe;
   // undriven ad shows the inverse of its last value, never a stale match
   assign ad_in = ad_h_oe ? ad_h : (!ad_oe_n ? ad_out : ~ad_h);
   initial
   begin
      frame_n = 1'b1;
      irdy_n = 1'b1;
      idsel = 1'b0;
      cbe_n = 4'hf;
      ad_h = 32'h0;
      ad_h_oe = 1'b0;
   end
   task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] addr,
      input logic [3:0] be_n, input logic [31:0] wd, output logic [31:0] rd, output logic ok,
      output pcs_claim_t cl);
      ok = 1'b0;
      rd = 32'h0;
      @(negedge clk);
      frame_n = 1'b0;
      idsel = sel;
      cbe_n = cmd;
      ad_h = addr;
      ad_h_oe = 1'b1;
      #1 cl = claim;
      @(negedge clk);
      frame_n = 1'b1;
      irdy_n = 1'b0;
      cbe_n = be_n;
      ad_h = wd;
      ad_h_oe = cmd[0];
      for (int n = 0; n < 6 && !ok; n++)
      begin
         @(posedge clk);
         ok = !trdy_n;
         rd = ad_out;
      end
      @(negedge clk);
      irdy_n = 1'b1;
      ad_h_oe = 1'b0;
      cbe_n = ~cbe_n;
      repeat (2) @(posedge clk);
   endtask
endmodule

// file: testbench/pcs_cfg_header_tb.sv
`timescale 1ns/1ps
module pcs_cfg_header_tb
   import pcs_pkg::*;
   ;
   localparam logic [15:0] MAN = 16'h4d2e; // arbitrary
   localparam logic [15:0] PART = 16'h7b31; // arbitrary
   localparam logic [7:0] REV = 8'h05;
   localparam logic [31:0] ID = {PART, MAN};
   localparam logic [31:0] CLS = {CLASS_VGA_DISPLAY, REV};
   logic clk, rst, frame_n, irdy_n, idsel, ad_oe_n, trdy_n, devsel_n, ok;
   logic [3:0] cbe_n;
   logic [31:0] ad_in, ad_out, rd;
   pcs_cfg_t cfg;
   pcs_claim_t claim, cl;
   int n_mismatch = 0;
   int compares = 0;
   logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h30, 8'h3c};
   logic [31:0] rst_v [6] = '{ID, 32'h0200_0000, CLS, 32'h0, 32'h0, 32'h0000_0100};
   logic [31:0] one_v [6] = '{ID, 32'h0200_0023, CLS, 32'hff80_0000, 32'hffff_0001, 32'h1ff};
   pcs_cfg_header #(.MANUFACTURER_CODE(MAN), .PART_CODE(PART), .REVISION(REV)) dut (.clk, .rst,
      .frame_n, .irdy_n, .idsel, .cbe_n, .ad_in, .ad_out, .ad_oe_n, .par_out(), .par_oe_n(),
      .trdy_n, .stop_n(), .devsel_n, .ctl_oe_n(), .cfg, .claim);
   pcs_host_model host (.clk, .ad_out, .ad_oe_n, .trdy_n, .claim, .frame_n, .irdy_n, .idsel,
      .cbe_n, .ad_in);
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_claim(input pcs_claim_t got, input pcs_claim_t exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdw(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(CMD_CFG_RD, 1'b1, {24'h0, a}, 4'h0, 32'h0, rd, ok, cl);
      chk_word({31'h0, ok}, 32'h1);
      chk_word(rd, exp);
   endtask
   task automatic wrw(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      host.xfer(CMD_CFG_WR, 1'b1, {24'h0, a}, be, d, rd, ok, cl);
   endtask
   task automatic probe(input logic [3:0] c, input logic [31:0] a, input pcs_claim_t exp);
      host.xfer(c, 1'b0, a, 4'h0, 32'h0, rd, ok, cl);
      chk_claim(cl, exp);
   endtask
   task automatic conclude();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 6; i++)
         rdw(ofs[i], rst_v[i]);
      for (int i = 0; i < 6; i++)
         wrw(ofs[i], 4'h0, 32'hffff_ffff);
      for (int i = 0; i < 6; i++)
         rdw(ofs[i], one_v[i]);
      chk_word({cfg.irq_line, cfg.rom_base, 6'h0, cfg.mem_en, cfg.io_en}, 32'hffff_ff03);
      for (int i = 0; i < 6; i++)
         wrw(ofs[i], 4'h0, 32'h0);
      for (int i = 0; i < 6; i++)
         rdw(ofs[i], rst_v[i]);
      wrw(OFS_MEMORY_WINDOW_BASE, 4'h7, 32'ha5a5_a5a5);
      rdw(OFS_MEMORY_WINDOW_BASE, 32'ha500_0000);
      wrw(OFS_IRQ_ROUTING, 4'h0, 32'h1234_5637);
      rdw(OFS_IRQ_ROUTING, 32'h0000_0137);
      host.xfer(CMD_CFG_RD, 1'b0, 32'h4, 4'h0, 32'h0, rd, ok, cl);
      chk_word({31'h0, ok}, 32'h0);
      wrw(OFS_COMMAND_CONTROL, 4'h0, 32'h3);
      wrw(OFS_MEMORY_WINDOW_BASE, 4'h0, 32'h1280_0000);
      wrw(OFS_ROM_WINDOW_BASE, 4'h0, 32'habcd_0001);
      probe(CMD_MEM_RD, 32'h1280_0040, 3'b010);
      probe(CMD_MEM_WR_INV, 32'h12ff_fffc, 3'h2);
      probe(CMD_MEM_WR, 32'habcd_0010, 3'b001);
      probe(CMD_IO_RD, 32'h0000_03c0, 3'b100);
      wrw(OFS_ROM_WINDOW_BASE, 4'h0, 32'habcd_0000);
      probe(CMD_MEM_RD_LINE, 32'habcd_0010, 3'b000);
      wrw(OFS_COMMAND_CONTROL, 4'h0, 32'h0);
      probe(CMD_IO_WR, 32'h0000_03c0, 3'b000);
      probe(CMD_MEM_RD_MULT, 32'h1280_0040, 3'b000);
      // reset in mid-run must clear every writable field again
      wrw(OFS_COMMAND_CONTROL, 4'h0, 32'h0000_0023);
      wrw(OFS_IRQ_ROUTING, 4'h0, 32'h0000_005a);
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 6; i++)
         rdw(ofs[i], rst_v[i]);
      conclude();
   end
   // about 55 transfers of under 16 cycles each, with wide margin
   initial
   begin
      #20000;
      n_mismatch++;
      conclude();
   end
endmodule
